// ### hdl/aps_shutdown_ctrl.sv
`default_nettype none
module aps_shutdown_ctrl
    import aps_pkg::*;
#(
    parameter int GAP_CYC = aps_pkg::BURST_GAP_CYC
) (
    input wire logic clk_sys, // System clock, 250 MHz
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic cs_n, // Chip select pin, active low
    input wire logic sclk, // Serial shift clock pin
    input wire logic din, // Serial configuration input pin
    input wire logic conv_done, // Conversion engine finished, pulse
    output logic conv_start, // Start a conversion, pulse
    output logic conv_dummy, // Running conversion is the dummy one
    output logic powered, // Analog section powered
    output logic shdn_req, // Shutdown requested in this cycle
    output aps_pkg::aps_state_t state // Control state
);
    import aps_pkg::*;

    localparam int GAP_W = $clog2(GAP_CYC + 1);
    localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(GAP_CYC);

    logic [SYNC_BITS-1:0] s_level;
    logic [SYNC_BITS-1:0] s_rise;
    logic [SYNC_BITS-1:0] s_fall;
    logic [CFG_BITS-2:0] cfg_shift;
    logic [CFG_CNT_W-1:0] rise_cnt;
    logic [CFG_CNT_W-1:0] fall_cnt;
    logic [GAP_W-1:0] gap_cnt;
    logic burst_idle;
    aps_state_t next_state;
    logic next_powered;

    aps_sync #(
        .W(SYNC_BITS)
    ) u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .pin({cs_n, sclk, din}),
        .level(s_level),
        .rise(s_rise),
        .fall(s_fall)
    );

    wire cs_low = ~s_level[SYNC_CS];
    wire cs_fall = s_fall[SYNC_CS];
    wire cs_high = s_level[SYNC_CS];
    wire sck_rise = s_rise[SYNC_SCLK] & cs_low;
    // Select may rise with the tenth fall; that fall still counts
    wire cs_was_low = cs_low | s_rise[SYNC_CS];
    wire sck_fall = s_fall[SYNC_SCLK] & cs_was_low;
    wire din_s = s_level[SYNC_DIN];
    wire [CFG_BITS-1:0] word_now = {cfg_shift, din_s};
    wire word_last = sck_rise && rise_cnt == CFG_CNT_W'(CFG_BITS - 1);
    wire shdn_code = word_now[WL_HI_POS] == WL_HI_SHDN &&
                     word_now[WL_LO_POS] == WL_LO_SHDN;
    // Conversion request; the conversion clock plays no part
    wire conv_req = cs_fall | (sck_rise & burst_idle);
    wire wake_req = cs_fall | sck_rise;
    wire shdn_edge = state == APS_ACTIVE && shdn_req && sck_fall &&
                     fall_cnt == SHDN_FALL_NUM - 4'h1;
    wire act_start = state == APS_ACTIVE && conv_req;
    wire shut_wake = state == APS_SHUT && wake_req;
    wire new_cycle = act_start | shut_wake;

    always_comb
    begin
        next_state = state;
        next_powered = powered;
        case (state)
            APS_ACTIVE:
            begin
                if (shdn_edge)
                begin
                    next_state = APS_DUMMY;
                end
            end
            APS_DUMMY:
            begin
                if (conv_done)
                begin
                    next_state = APS_SHUT;
                    next_powered = 1'h0;
                end
            end
            APS_SHUT:
            begin
                if (wake_req)
                begin
                    next_state = APS_ACTIVE;
                    next_powered = 1'h1;
                end
            end
            default:
            begin
                next_state = APS_ACTIVE;
                next_powered = 1'h1;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= APS_ACTIVE;
            powered <= RESET_POWERED;
        end
        else
        begin
            state <= next_state;
            powered <= next_powered;
        end
    end

    // Start pulse: real conversion on a request, dummy on shutdown entry
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            conv_start <= 1'h0;
            conv_dummy <= 1'h0;
        end
        else
        begin
            conv_start <= new_cycle | shdn_edge;
            if (shdn_edge)
            begin
                conv_dummy <= 1'h1;
            end
            else if (new_cycle || next_state != APS_DUMMY)
            begin
                conv_dummy <= 1'h0;
            end
        end
    end

    // Serial edge counters, restarted by each new conversion cycle outside the dummy state and cleared while select is high
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rise_cnt <= 4'h0;
            fall_cnt <= 4'h0;
            cfg_shift <= '0;
        end
        else if (cs_high)
        begin
            rise_cnt <= 4'h0;
            fall_cnt <= 4'h0;
        end
        else if (new_cycle)
        begin
            rise_cnt <= sck_rise ? 4'h1 : 4'h0;
            fall_cnt <= 4'h0;
            if (sck_rise)
            begin
                cfg_shift <= {cfg_shift[CFG_BITS-3:0], din_s};
            end
        end
        else
        begin
            if (sck_rise && rise_cnt != CNT_MAX)
            begin
                rise_cnt <= rise_cnt + 4'h1;
                cfg_shift <= {cfg_shift[CFG_BITS-3:0], din_s};
            end
            if (sck_fall && fall_cnt != CNT_MAX)
            begin
                fall_cnt <= fall_cnt + 4'h1;
            end
        end
    end

    // Shutdown request, held for the current serial cycle only
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            shdn_req <= 1'h0;
        end
        else if (cs_high || new_cycle || shdn_edge)
        begin
            shdn_req <= 1'h0;
        end
        else if (word_last && state == APS_ACTIVE)
        begin
            shdn_req <= shdn_code;
        end
    end

    // A burst ends after a quiet gap; select high also ends it
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            gap_cnt <= '0;
            burst_idle <= 1'h1;
        end
        else if (cs_high || (state == APS_DUMMY && conv_done))
        begin
            gap_cnt <= '0;
            burst_idle <= 1'h1;
        end
        // The burst that follows a select fall belongs to that request
        else if (cs_fall || sck_rise || s_fall[SYNC_SCLK])
        begin
            gap_cnt <= '0;
            burst_idle <= 1'h0;
        end
        else if (gap_cnt == GAP_LAST)
        begin
            burst_idle <= 1'h1;
        end
        else
        begin
            gap_cnt <= gap_cnt + GAP_W'(1);
        end
    end

    AST_SHDN_CODE: assert property (@(posedge clk_sys) disable iff (!resetn)
        word_last && state == APS_ACTIVE && shdn_code && !new_cycle
        |=> shdn_req)
        else $error("shutdown code not recognised");

    AST_NO_SHDN_CODE: assert property (@(posedge clk_sys) disable iff (!resetn)
        word_last && !shdn_code |=> !shdn_req)
        else $error("shutdown flagged for other word length");

    AST_TENTH_FALL: assert property (@(posedge clk_sys) disable iff (!resetn)
        state == APS_ACTIVE && shdn_req && sck_fall && fall_cnt == 4'h9
        |=> state == APS_DUMMY && conv_start && conv_dummy)
        else $error("shutdown not entered at tenth falling edge");

    AST_EARLY: assert property (@(posedge clk_sys) disable iff (!resetn)
        state == APS_ACTIVE && fall_cnt < 4'h9 |=> state != APS_DUMMY)
        else $error("shutdown entered too early");

    AST_DUMMY_IDLE: assert property (@(posedge clk_sys) disable iff (!resetn)
        state == APS_DUMMY && conv_done
        |=> state == APS_SHUT && !powered && !conv_start && !conv_dummy)
        else $error("dummy conversion did not end in shutdown");

    AST_WAKE: assert property (@(posedge clk_sys) disable iff (!resetn)
        state == APS_SHUT && (cs_fall || sck_rise)
        |=> powered && conv_start && !conv_dummy ##1 !conv_start)
        else $error("no immediate conversion on wake");

    AST_STAY_SHUT: assert property (@(posedge clk_sys) disable iff (!resetn)
        state == APS_SHUT && !cs_fall && !sck_rise
        |=> !powered && !conv_start && state == APS_SHUT)
        else $error("left shutdown without a request");

    AST_CS_REQ: assert property (@(posedge clk_sys) disable iff (!resetn)
        state == APS_ACTIVE && $fell(s_level[SYNC_CS]) |=> conv_start)
        else $error("select fall did not start a conversion");

    AST_LATE_CLK: assert property (@(posedge clk_sys) disable iff (!resetn)
        state == APS_DUMMY && conv_done ##1 sck_rise
        |=> powered && state == APS_ACTIVE)
        else $error("late serial clock did not wake");

    COV_SHUT: cover property (@(posedge clk_sys) disable iff (!resetn)
        state == APS_DUMMY ##[1:200] state == APS_SHUT);
    COV_WAKE_CS: cover property (@(posedge clk_sys) disable iff (!resetn)
        state == APS_SHUT && cs_fall);
    COV_WAKE_CLK: cover property (@(posedge clk_sys) disable iff (!resetn)
        state == APS_SHUT && sck_rise);
    COV_BURST: cover property (@(posedge clk_sys) disable iff (!resetn)
        state == APS_ACTIVE && sck_rise && burst_idle && !cs_fall);
endmodule
`default_nettype wire

// ### hdl/aps_sync.sv
`default_nettype none
module aps_sync #(
    parameter int W = 3
) (
    input wire logic clk_sys, // System clock
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic [W-1:0] pin, // Asynchronous pin levels
    output logic [W-1:0] level, // Synchronised level
    output logic [W-1:0] rise, // One-cycle pulse on a rising edge
    output logic [W-1:0] fall // One-cycle pulse on a falling edge
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge clk_sys or negedge resetn)
            begin
                if (!resetn)
                begin
                    stage1[i] <= 1'h1;
                    stage2[i] <= 1'h1;
                    stage3[i] <= 1'h1;
                end
                else
                begin
                    stage1[i] <= pin[i];
                    stage2[i] <= stage1[i];
                    stage3[i] <= stage2[i];
                end
            end
            assign level[i] = stage2[i];
            assign rise[i] = stage2[i] & ~stage3[i];
            assign fall[i] = ~stage2[i] & stage3[i];
        end
    endgenerate
endmodule
`default_nettype wire

// ### include/aps_pkg.sv
`default_nettype none
package aps_pkg;
    // Configuration word shifted in MSB first on rising serial clock edges
    localparam int CFG_BITS = 8;
    localparam int CFG_CNT_W = 4;
    localparam int WL_HI_POS = 1;
    localparam int WL_LO_POS = 0;
    localparam logic WL_HI_SHDN = 1'h0;
    localparam logic WL_LO_SHDN = 1'h1;
    // Shutdown starts at this falling serial clock edge
    localparam logic [CFG_CNT_W-1:0] SHDN_FALL_NUM = 4'hA;
    localparam logic [CFG_CNT_W-1:0] CNT_MAX = 4'hF;
    // Quiet time on the serial clock that closes a burst
    localparam int BURST_GAP_NS = 1024;
    localparam int CLK_PERIOD_NS = 4;
    localparam int BURST_GAP_CYC = BURST_GAP_NS / CLK_PERIOD_NS;
    localparam int SYNC_BITS = 3;
    localparam int SYNC_CS = 2;
    localparam int SYNC_SCLK = 1;
    localparam int SYNC_DIN = 0;
    localparam logic RESET_POWERED = 1'h1;

    typedef enum logic [1:0]
    {
        APS_ACTIVE = 2'h0,
        APS_DUMMY = 2'h1,
        APS_SHUT = 2'h3
    } aps_state_t;
endpackage
`default_nettype wire

// ### test/adc_power_shutdown_control_tb.sv
`default_nettype none
module adc_power_shutdown_control_tb;
    import aps_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic conv_done = 1'b0;
    logic poke = 1'b0;
    logic cs_n, sclk, din, conv_start, conv_dummy, powered, shdn_req;
    aps_state_t state;
    int falls, eng = 0, starts = 0, dummy_fall = 0, s0 = 0;
    int error_cnt = 0;
    int num_checks = 0;
    bit shut_seen = 0;
    always #2 clk_sys = ~clk_sys;
    aps_host_model u_host (.clk_sys(clk_sys), .cs_n(cs_n), .sclk(sclk),
        .din(din), .falls(falls));
    aps_shutdown_ctrl #(.GAP_CYC(32)) u_aps_shutdown_ctrl (
        .clk_sys(clk_sys), .resetn(resetn), .cs_n(cs_n), .sclk(sclk),
        .din(din), .conv_done(conv_done), .conv_start(conv_start),
        .conv_dummy(conv_dummy), .powered(powered), .shdn_req(shdn_req),
        .state(state));
    // Engine model finishes each conversion 9 cycles after its start
    always @(posedge clk_sys)
    begin
        conv_done <= (eng == 1) || poke;
        eng <= conv_start ? 8 : (eng > 0 ? eng - 1 : 0);
        if (conv_start === 1'b1)
            starts <= starts + 1;
        if (state === APS_DUMMY && dummy_fall == 0)
            dummy_fall <= falls;
        if (state === APS_SHUT)
            shut_seen <= 1;
    end
    task automatic check(input int got, input int exp, input string msg);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic look(input logic [1:0] st, input logic pw);
        check(state === st, 1, "state");
        check(powered === pw, 1, "powered");
    endtask
    task automatic wait_state(input aps_state_t s);
        int n;
        for (n = 0; n < 400 && state !== s; n++)
        begin
            @(posedge clk_sys);
            #1;
        end
        if (n == 400)
        begin
            error_cnt++;
            $display("wrong value at %0t: state wait timed out", $time);
            test_done();
        end
    endtask
    task automatic settle();
        repeat (20) @(posedge clk_sys);
        #1;
    endtask
    task automatic t_reset();
        look(APS_ACTIVE, 1'b1);
        check(conv_start === 1'b0 && conv_dummy === 1'b0, 1, "start");
        check(shdn_req === 1'b0, 1, "shdn_req");
        $display("test reset done");
    endtask
    task automatic t_plain();
        s0 = starts;
        u_host.frame(8'hFF, 12, 0);
        settle();
        check(starts - s0, 1, "one start per frame");
        look(APS_ACTIVE, 1'b1);
        $display("test plain done");
    endtask
    task automatic t_shut();
        s0 = starts;
        dummy_fall = 0;
        u_host.frame(8'h3D, 10, 0);
        wait_state(APS_SHUT);
        check(dummy_fall, 10, "shutdown edge");
        check(starts - s0, 2, "dummy conversion");
        check(conv_dummy === 1'b0, 1, "dummy flag");
        look(APS_SHUT, 1'b0);
        @(posedge clk_sys) poke <= 1'b1;
        @(posedge clk_sys) poke <= 1'b0;
        repeat (60) @(posedge clk_sys);
        look(APS_SHUT, 1'b0);
        s0 = starts;
        u_host.frame(8'hFF, 12, 0);
        settle();
        look(APS_ACTIVE, 1'b1);
        check(starts - s0, 1, "wake converts");
        $display("test shutdown done");
    endtask
    task automatic t_late();
        s0 = starts;
        shut_seen = 0;
        u_host.frame(8'h3D, 16, 0);
        settle();
        check(shut_seen, 1, "shut reached");
        look(APS_ACTIVE, 1'b1);
        check(starts - s0, 3, "late clocks wake");
        $display("test late clocks done");
    endtask
    task automatic t_burst();
        u_host.frame(8'h3D, 10, 1);
        wait_state(APS_SHUT);
        repeat (40) @(posedge clk_sys);
        look(APS_SHUT, 1'b0);
        u_host.burst(8'h00, 4);
        settle();
        look(APS_ACTIVE, 1'b1);
        s0 = starts;
        repeat (40) @(posedge clk_sys);
        u_host.burst(8'hFF, 4);
        settle();
        check(starts - s0, 1, "new burst converts");
        u_host.idle();
        settle();
        $display("test burst done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        #13;
        t_reset();
        t_plain();
        t_shut();
        t_late();
        t_burst();
        test_done();
    end
endmodule
`default_nettype wire

// ### test/aps_host_model.sv
`default_nettype none
module aps_host_model (
    input wire logic clk_sys, // Bench clock that paces the pins
    output logic cs_n, // Chip select, active low
    output logic sclk, // Serial clock, still outside frames
    output logic din, // Serial data
    output var int falls // Falling sclk edges in this frame
);
    timeunit 1ns;
    timeprecision 100ps;
    // Half a 64 ns serial clock period, in system clock cycles
    localparam int HALF_CYC = 8;
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
        falls = 0;
    end
    task automatic half();
        repeat (HALF_CYC) @(posedge clk_sys);
    endtask
    // Word MSB first over n clocks, then select released unless kept low
    task automatic frame(input logic [7:0] word, input int n, input bit keep);
        @(posedge clk_sys);
        cs_n <= 1'b0;
        falls <= 0;
        half();
        burst(word, n);
        if (!keep)
            cs_n <= 1'b1;
    endtask
    // Data past the word toggles so a stale level is never mistaken
    task automatic burst(input logic [7:0] word, input int n);
        @(posedge clk_sys);
        for (int i = 0; i < n; i++)
        begin
            din <= (i < 8) ? word[7 - i] : ~din;
            half();
            sclk <= 1'b1;
            half();
            sclk <= 1'b0;
            falls <= falls + 1;
        end
        din <= ~din;
    endtask
    task automatic idle();
        @(posedge clk_sys);
        cs_n <= 1'b1;
    endtask
endmodule
`default_nettype wire
